// ### gfs_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: Default mode passes each optical input straight to its gate output.
// R2: Gates derive from optical commands; optional switching-state decode supported.
// R3: Active fault overrides gating with blocked or short pattern by cause.
// R4: Output flags derived from fast sampler and slow supervisor faults.
// R5: Fast sampler checks voltage and current at about 150 ksps.
// R6: Slow supervisor flags temperature or supply out of range continuously.
// R7: Limits: current over 30 A, half bus over 450 V, over 90 degC.
// R8: Supply fault below 4.5 V or above 5.5 V.
// R9: Global error line is active low, pulled low on any fault.
// R10: Latched fault holds until the manual acknowledge button is pressed.
// R11: Global error is forwarded to the master controller.
// R12: Safe state held while latched, even after sampler flags clear.
module gfs_supervisor (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_ce,
    input  wire logic [3:0]            i_opt,
    input  wire gfs_pkg::gfs_mode_t    i_mode,
    input  wire logic [gfs_pkg::FAULT_W-1:0] i_short_sel,
    input  wire gfs_pkg::gfs_fast_t    i_fast,
    input  wire gfs_pkg::gfs_slow_t    i_slow,
    input  wire logic                  i_ack_btn,
    output logic [3:0]                 o_gate,
    output gfs_pkg::gfs_flags_t        o_flags,
    output logic                       o_err_n
);
    import gfs_pkg::*;

    localparam logic [15:0] DIV_LAST = 16'(FAST_DIV - 1);
    localparam logic [15:0] DIV_CNT  = 16'(FAST_DIV);
    // Gate patterns for the three output levels; the zero level uses both inner switches
    localparam logic [3:0]  PAT_NEG  = 4'h3;
    localparam logic [3:0]  PAT_ZERO = 4'h6;
    localparam logic [3:0]  PAT_POS  = 4'hC;
    // Switching-state codes carried on the two low fibres
    localparam logic [1:0]  ST_NEG   = 2'b00;
    localparam logic [1:0]  ST_ZERO  = 2'b01;
    localparam logic [1:0]  ST_POS   = 2'b10;

    // Elaboration checks: the strobe counter is 16 bits and the gate path four switches wide
    if (FAST_DIV < 2 || FAST_DIV > 65535) begin : g_div_chk
        $error("fast sample divider does not fit the strobe counter");
    end
    if (GATE_W != 4) begin : g_gate_chk
        $error("gate width differs from the four optical inputs");
    end
    if (F_SUP >= FAULT_W || F_VLOW >= F_TEMP) begin : g_cause_chk
        $error("fault cause indices do not split into fast and slow groups");
    end

    // Three-level switching-state decode; the unused code blocks every switch
    function automatic logic [3:0] decode_state(input logic [1:0] st);
        case (st)
            ST_NEG:  decode_state = PAT_NEG;
            ST_ZERO: decode_state = PAT_ZERO;
            ST_POS:  decode_state = PAT_POS;
            default: decode_state = GATE_BLOCK;
        endcase
    endfunction

    logic [15:0]        div_r;
    logic [15:0]        div_nxt;
    logic               stb_r;
    logic               stb_nxt;
    logic [FAULT_W-1:0] over;
    logic [FAULT_W-1:0] latch_r;
    logic [FAULT_W-1:0] latch_nxt;
    logic [3:0]         gate_r;
    logic [3:0]         gate_nxt;
    gfs_flags_t         flags_r;
    gfs_flags_t         flags_nxt;
    logic               err_n_r;
    logic               err_n_nxt;

    // Sample strobe at fast sampler rate
    always_comb begin
        stb_nxt = (div_r == DIV_LAST);                   // R5
        div_nxt = stb_nxt ? '0 : div_r + 16'h0001;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_r <= '0;
            stb_r <= 1'b0;
        end else if (i_ce) begin
            div_r <= div_nxt;
            stb_r <= stb_nxt;
        end
    end

    // Check-only counter of enabled cycles since the last strobe, so the sample
    // spacing is judged apart from the divider that makes it
    logic [15:0]        gap_r;
    logic [15:0]        gap_nxt;

    always_comb begin
        gap_nxt = stb_r ? 16'h0000 : gap_r + 16'h0001;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gap_r <= 16'h0000;
        end else if (i_ce) begin
            gap_r <= gap_nxt;
        end
    end

    gfs_comparator u_cmp (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_ce       (i_ce),
        .i_fast_stb (stb_r),
        .i_fast     (i_fast),
        .i_slow     (i_slow),
        .o_over     (over)
    );

    // Fault latch; a live fault beats the acknowledge so it is never lost
    always_comb begin
        latch_nxt = latch_r;
        if (i_ack_btn) begin
            latch_nxt = '0;                              // R10
        end
        latch_nxt = latch_nxt | over;                    // R10 R12
    end

    // Gating: command path, overridden by safe pattern while latched
    always_comb begin
        logic [FAULT_W-1:0] act;
        act = latch_nxt;
        if (i_mode == GFS_MODE_STATE) begin
            gate_nxt = decode_state(i_opt[1:0]);         // R2
        end else begin
            gate_nxt = i_opt;                            // R1
        end
        if (|act) begin
            // Short pattern only when every active cause asks for it
            gate_nxt = ((act & ~i_short_sel) == '0) ? GATE_SHORT : GATE_BLOCK; // R3 R12
        end
    end

    // Flags and active-low error line
    always_comb begin
        flags_nxt.cause = latch_nxt;                     // R4
        flags_nxt.fast  = |latch_nxt[F_VLOW:F_CUR];      // R4
        flags_nxt.slow  = |latch_nxt[F_SUP:F_TEMP];      // R4
        err_n_nxt       = ~(|latch_nxt);                 // R9 R11
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            latch_r <= '0;
            gate_r  <= GATE_RST;
            flags_r <= '0;
            err_n_r <= 1'b1;
        end else if (i_ce) begin
            latch_r <= latch_nxt;
            gate_r  <= gate_nxt;
            flags_r <= flags_nxt;
            err_n_r <= err_n_nxt;
        end
    end

    assign o_gate  = gate_r;
    assign o_flags = flags_r;
    assign o_err_n = err_n_r;

    sequence s_fault;
        i_ce && (|over);
    endsequence

    property p_err_low;
        @(posedge i_clk) disable iff (!i_nrst) s_fault |=> !o_err_n;
    endproperty
    a_err_low: assert property (p_err_low) else $error("error line not low after fault"); // R9

    property p_hold;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_ce && !o_err_n && !i_ack_btn) |=> !o_err_n;
    endproperty
    a_hold: assert property (p_hold) else $error("fault cleared without acknowledge"); // R10

    property p_safe;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_ce && (|latch_nxt)) |=> (o_gate == GATE_BLOCK || o_gate == GATE_SHORT);
    endproperty
    a_safe: assert property (p_safe) else $error("gates not safe during fault"); // R3

    property p_direct;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_ce && latch_nxt == '0 && i_mode == GFS_MODE_DIRECT) |=> o_gate == $past(i_opt);
    endproperty
    a_direct: assert property (p_direct) else $error("direct pass-through broken"); // R1

    property p_sticky;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_ce && (|latch_r) && !i_ack_btn) |=> (|latch_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("latch dropped with flags normal"); // R12

    property p_flags;
        @(posedge i_clk) disable iff (!i_nrst) o_flags.cause != '0 |-> !o_err_n;
    endproperty
    a_flags: assert property (p_flags) else $error("flag without error line"); // R4

    property p_stb;
        @(posedge i_clk) disable iff (!i_nrst) (i_ce && stb_r) |=> !stb_r;
    endproperty
    a_stb: assert property (p_stb) else $error("sample strobe too long"); // R5

    property p_ok;
        @(posedge i_clk) disable iff (!i_nrst) o_err_n |-> o_flags.cause == '0;
    endproperty
    a_ok: assert property (p_ok) else $error("error line high with cause set"); // R11

    // Strobe spacing: never further apart than one divider period, never closer
    property p_gap_max;
        @(posedge i_clk) disable iff (!i_nrst) (i_ce && !stb_r) |-> gap_r < DIV_CNT;
    endproperty
    a_gap_max: assert property (p_gap_max) else $error("fast sample strobe missing"); // R5

    property p_gap_min;
        @(posedge i_clk) disable iff (!i_nrst) (i_ce && stb_r) |-> gap_r >= DIV_LAST;
    endproperty
    a_gap_min: assert property (p_gap_min) else $error("fast sample strobe too early"); // R5

    // A compare hit reaches its group flag and the error line one edge later
    sequence s_fast_trip;
        i_ce && (|over[F_VLOW:F_CUR]);
    endsequence

    property p_fast_flag;
        @(posedge i_clk) disable iff (!i_nrst) s_fast_trip |=> (o_flags.fast && !o_err_n);
    endproperty
    a_fast_flag: assert property (p_fast_flag) else $error("fast fault not flagged"); // R4 R5

    sequence s_slow_trip;
        i_ce && (|over[F_SUP:F_TEMP]);
    endsequence

    property p_slow_flag;
        @(posedge i_clk) disable iff (!i_nrst) s_slow_trip |=> (o_flags.slow && !o_err_n);
    endproperty
    a_slow_flag: assert property (p_slow_flag) else $error("slow fault not flagged"); // R4 R6

    // Group flags always agree with the cause bits they summarise
    property p_group;
        @(posedge i_clk) disable iff (!i_nrst)
            (o_flags.fast == (|o_flags.cause[F_VLOW:F_CUR])) &&
            (o_flags.slow == (|o_flags.cause[F_SUP:F_TEMP]));
    endproperty
    a_group: assert property (p_group) else $error("group flag disagrees with causes"); // R4

    // Acknowledge with no live fault: error line and flags clear on the next edge
    sequence s_ack_clean;
        i_ce && i_ack_btn && (over == '0);
    endsequence

    sequence s_cleared;
        o_err_n && (o_flags == '0);
    endsequence

    property p_ack_clear;
        @(posedge i_clk) disable iff (!i_nrst) s_ack_clean |=> s_cleared;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear"); // R10

    // Safe pattern choice: short only when every latched cause asks for it
    property p_short;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_ce && (|latch_nxt) && ((latch_nxt & ~i_short_sel) == '0)) |=> o_gate == GATE_SHORT;
    endproperty
    a_short: assert property (p_short) else $error("short pattern not applied"); // R3

    property p_block;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_ce && ((latch_nxt & ~i_short_sel) != '0)) |=> o_gate == GATE_BLOCK;
    endproperty
    a_block: assert property (p_block) else $error("block pattern not applied"); // R3

    // Decoded mode follows the two low command bits when no fault is latched
    property p_decode;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_ce && (latch_nxt == '0) && (i_mode == GFS_MODE_STATE)) |=>
            o_gate == decode_state(2'($past(i_opt)));
    endproperty
    a_decode: assert property (p_decode) else $error("state decode broken"); // R2

    // Error line goes low only with a cause behind it
    property p_err_cause;
        @(posedge i_clk) disable iff (!i_nrst) !o_err_n |-> o_flags.cause != '0;
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error line low without cause"); // R9

    // A low enable freezes every output
    property p_freeze;
        @(posedge i_clk) disable iff (!i_nrst)
            !i_ce |=> ($stable(o_gate) && $stable(o_err_n) && $stable(o_flags));
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved with clock enable low");
endmodule
`default_nettype wire

// ### gfs_pkg.sv
package gfs_pkg;
    // Gate path width
    localparam int unsigned GATE_W     = 4;
    // Fault source indices
    localparam int unsigned F_CUR      = 0;
    localparam int unsigned F_VUP      = 1;
    localparam int unsigned F_VLOW     = 2;
    localparam int unsigned F_TEMP     = 3;
    localparam int unsigned F_SUP      = 4;
    localparam int unsigned FAULT_W    = 5;
    // Threshold defaults in engineering units (sampler codes use same scale)
    localparam logic [15:0] CUR_LIM_A  = 16'h001E;  // 30 A
    localparam logic [15:0] VDC_LIM_V  = 16'h01C2;  // 450 V
    localparam logic [15:0] TEMP_LIM_C = 16'h005A;  // 90 degC
    localparam logic [15:0] SUP_MIN_MV = 16'h1194;  // 4500 mV
    localparam logic [15:0] SUP_MAX_MV = 16'h157C;  // 5500 mV
    // Safe patterns
    localparam logic [3:0]  GATE_BLOCK = 4'h0;
    localparam logic [3:0]  GATE_SHORT = 4'h6;      // Both inner switches on
    localparam logic [3:0]  GATE_RST   = 4'h0;
    // Fast sampler timing: 150 ksps at 250 MHz
    localparam int unsigned CLK_HZ     = 250000000;
    localparam int unsigned FAST_SPS   = 150000;
    localparam int unsigned FAST_DIV   = CLK_HZ / FAST_SPS;

    // Gating decode modes
    typedef enum logic [1:0] {
        GFS_MODE_DIRECT = 2'b00,
        GFS_MODE_STATE  = 2'b01
    } gfs_mode_t;

    // Measurement samples
    typedef struct packed {
        logic [15:0] cur_abs;
        logic [15:0] v_up;
        logic [15:0] v_low;
    } gfs_fast_t;

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] sup_mv;
    } gfs_slow_t;

    // Fault flags out
    typedef struct packed {
        logic fast;
        logic slow;
        logic [FAULT_W-1:0] cause;
    } gfs_flags_t;
endpackage

// ### gfs_comparator.sv
`timescale 1ns/1ns
`default_nettype none
// Compares samples with limits; fast samples taken on a strobe, slow ones every cycle
module gfs_comparator (
    input  wire logic                     i_clk,
    input  wire logic                     i_nrst,
    input  wire logic                     i_ce,
    input  wire logic                     i_fast_stb,
    input  wire gfs_pkg::gfs_fast_t       i_fast,
    input  wire gfs_pkg::gfs_slow_t       i_slow,
    output logic [gfs_pkg::FAULT_W-1:0]   o_over
);
    import gfs_pkg::*;

    logic [FAULT_W-1:0] over_r;
    logic [FAULT_W-1:0] over_nxt;

    // Fast channels update at sample rate, slow ones every cycle
    always_comb begin
        over_nxt = over_r;
        if (i_fast_stb) begin
            over_nxt[F_CUR]  = i_fast.cur_abs > CUR_LIM_A;  // R5 R7
            over_nxt[F_VUP]  = i_fast.v_up > VDC_LIM_V;     // R7
            over_nxt[F_VLOW] = i_fast.v_low > VDC_LIM_V;    // R7
        end
        over_nxt[F_TEMP] = i_slow.temp > TEMP_LIM_C;        // R6 R7
        over_nxt[F_SUP]  = (i_slow.sup_mv < SUP_MIN_MV) ||
                           (i_slow.sup_mv > SUP_MAX_MV);    // R8
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            over_r <= '0;
        end else if (i_ce) begin
            over_r <= over_nxt;
        end
    end

    assign o_over = over_r;
endmodule
`default_nettype wire

// ### gfs_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// Master controller end of the fibres
// Commands arrive registered, as through a fibre receiver
module gfs_master_model (
    input  wire logic       i_clk,
    input  wire logic [3:0] i_cmd,
    output var  logic [3:0] o_opt = 4'h0
);
    // Change only just after an edge, so the block never samples a moving line
    always @(posedge i_clk) begin
        o_opt <= i_cmd;
    end
endmodule
`default_nettype wire

// ### tb_gfs_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module tb_gfs_supervisor;
    import gfs_pkg::*;
    localparam gfs_fast_t FOK = {16'h0005, 16'h0064, 16'h0064};
    localparam gfs_slow_t SOK = {16'h0019, 16'h1388};
    logic       clk  = 0;
    logic       nrst = 0;
    logic       ce   = 1;
    logic [3:0] cmd  = 4'h0;
    logic [3:0] opt;
    gfs_mode_t  mode = GFS_MODE_DIRECT;
    logic [4:0] ssel = 5'h00;
    gfs_fast_t  fast = FOK;
    gfs_slow_t  slow = SOK;
    logic       ack  = 0;
    logic [3:0] gate;
    gfs_flags_t flags;
    logic       err_n;
    int         fail_count  = 0;
    int         comparisons = 0;

    // Free-running 250 MHz clock
    always #2 clk = ~clk;

    gfs_master_model u_gfs_master_model (.i_clk(clk), .i_cmd(cmd), .o_opt(opt));
    gfs_supervisor u_gfs_supervisor (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_opt(opt), .i_mode(mode),
        .i_short_sel(ssel), .i_fast(fast), .i_slow(slow), .i_ack_btn(ack), .o_gate(gate),
        .o_flags(flags), .o_err_n(err_n));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded wait: the fast strobe may be up to 1666 cycles away
    task automatic wait_err(input logic lvl);
        for (int i = 0; i < 1800 && err_n !== lvl; i++) @(posedge clk);
        cyc(2);
        @(negedge clk);
    endtask

    task automatic t_direct;
        for (int i = 0; i < 16; i++) begin
            cmd <= 4'(i);
            cyc(3);
            @(negedge clk);
            chk(8'(gate), 8'(i));
            @(posedge clk);
        end
        $display("t_direct done");
    endtask
    // Upper command bits set on purpose: decode must ignore them
    task automatic t_decode;
        logic [3:0] tbl [4] = '{4'h3, 4'h6, 4'hC, 4'h0};
        mode <= GFS_MODE_STATE;
        for (int i = 0; i < 4; i++) begin
            cmd <= {2'b11, 2'(i)};
            cyc(3);
            @(negedge clk);
            chk(8'(gate), 8'(tbl[i]));
            @(posedge clk);
        end
        mode <= GFS_MODE_DIRECT;
        $display("t_decode done");
    endtask
    // Values exactly at each limit must not trip
    task automatic t_limits;
        fast <= {CUR_LIM_A, VDC_LIM_V, VDC_LIM_V};
        slow <= {TEMP_LIM_C, SUP_MIN_MV};
        cyc(1800);
        slow <= {TEMP_LIM_C, SUP_MAX_MV};
        cyc(4);
        @(negedge clk);
        chk(8'(err_n), 8'h01);
        @(posedge clk);
        fast <= FOK;
        slow <= SOK;
        $display("t_limits done");
    endtask
    task automatic t_fault(input gfs_fast_t f, input gfs_slow_t s, input logic [4:0] sel,
                           input logic [3:0] safe, input logic [6:0] ef);
        cmd <= 4'hF;
        ssel <= sel;
        cyc(3);
        fast <= f;
        slow <= s;
        wait_err(1'b0);
        chk(8'(err_n), 8'h00);
        chk(8'(gate), 8'(safe));
        chk(8'(flags), 8'(ef));
        @(posedge clk);
        ack <= 1;
        cyc(4);
        @(negedge clk);
        chk(8'(err_n), 8'h00);
        @(posedge clk);
        ack <= 0;
        fast <= FOK;
        slow <= SOK;
        cyc(1800);
        @(negedge clk);
        chk(8'(gate), 8'(safe));
        @(posedge clk);
        ack <= 1;
        wait_err(1'b1);
        chk(8'(err_n), 8'h01);
        chk(8'(gate), 8'hF);
        @(posedge clk);
        ack <= 0;
        $display("t_fault done");
    endtask

    // Enable low freezes the block; the fault it missed is taken once enable returns
    task automatic t_ce;
        ce <= 1'b0;
        cmd <= 4'h5;
        slow <= {16'h005B, 16'h1388};
        cyc(6);
        @(negedge clk);
        chk(8'({err_n, gate}), 8'h1F);
        @(posedge clk);
        ce <= 1'b1;
        cyc(2);
        @(negedge clk);
        chk(8'({err_n, gate}), 8'h00);
        chk(8'(flags), 8'h28);
        @(posedge clk);
        slow <= SOK;
        ack <= 1'b1;
        cyc(3);
        @(negedge clk);
        chk(8'({err_n, gate}), 8'h15);
        @(posedge clk);
        ack <= 1'b0;
        $display("t_ce done");
    endtask
    // Reset in mid-run drops a latched fault and restarts from the reset values
    task automatic t_rst;
        slow <= {16'h005B, 16'h1388};
        cyc(3);
        @(negedge clk);
        chk(8'(err_n), 8'h00);
        @(posedge clk);
        nrst <= 1'b0;
        slow <= SOK;
        cyc(3);
        @(negedge clk);
        chk(8'({err_n, gate}), 8'h10);
        chk(8'(flags), 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        cyc(3);
        @(negedge clk);
        chk(8'({err_n, gate}), 8'h15);
        $display("t_rst done");
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 18000 cycles the tests need
    initial begin
        #240000;
        fail_count++;
        end_sim();
    end

    initial begin
        cyc(4);
        @(negedge clk);
        chk(8'({err_n, gate}), 8'h10);
        @(posedge clk);
        nrst <= 1;
        t_direct();
        t_decode();
        t_limits();
        t_fault(FOK, {16'h005B, 16'h1388}, 5'h08, 4'h6, 7'h28);
        t_fault(FOK, {16'h0019, 16'h1193}, 5'h08, 4'h0, 7'h30);
        t_fault(FOK, {16'h0019, 16'h157D}, 5'h00, 4'h0, 7'h30);
        t_fault({16'h001F, 16'h0064, 16'h0064}, SOK, 5'h01, 4'h6, 7'h41);
        t_fault({16'h0005, 16'h01C3, 16'h0064}, SOK, 5'h00, 4'h0, 7'h42);
        t_fault({16'h0005, 16'h0064, 16'h01C3}, SOK, 5'h00, 4'h0, 7'h44);
        t_ce();
        t_rst();
        end_sim();
    end
endmodule
`default_nettype wire
